/* File: sarc_pkg.sv */
// constants and types for the converter control block
package sarc_pkg;
  localparam int RES_W = 10;
  localparam logic [4:0] CONV_NORM_END = 5'h0C;
  localparam logic [4:0] CONV_FIRST_END = 5'h18;
  localparam logic [4:0] CONV_AUTO_END = 5'h0D;
  localparam logic [4:0] SAMP_NORM = 5'h01;
  localparam logic [4:0] SAMP_FIRST = 5'h0D;
  localparam logic [4:0] SAMP_AUTO = 5'h01;
  localparam logic [4:0] DIFF_EXTRA = 5'h01;
  localparam logic [2:0] TRIG_FREE = 3'h0;
  localparam logic [4:0] DIFF_LO = 5'h08;
  localparam logic [4:0] DIFF_HI = 5'h1D;
  localparam logic [9:0] DAC_MID = 10'h200;
  localparam logic [3:0] BIT_TOP = 4'h9;
  localparam logic [9:0] PRESC_BASE = 10'h004;
  localparam logic [9:0] PRESC_HALF = 10'h002;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sarc_state_t;

  typedef struct packed {
    sarc_state_t st;
    logic [4:0] cyc;
    logic [4:0] end_cyc;
    logic end_fall;
    logic [4:0] samp_cyc;
    logic samp_fall;
    logic sampled;
    logic bits_on;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [9:0] dac;
    logic hold;
    logic [9:0] res;
    logic [7:0] hi;
    logic [7:0] lo;
    logic lock;
    logic flag;
    logic go;
    logic first;
    logic auto;
    logic [4:0] chan;
    logic [1:0] refs;
    logic trig_d;
    logic [2:0] tpipe;
    logic cmp_m;
    logic cmp_s;
  } sarc_st_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic rise;
    logic fall;
    logic hrs;
  } sarc_presc_st_t;

  localparam sarc_st_t SARC_RST = '0;
  localparam sarc_presc_st_t PRESC_RST = '0;
endpackage

/* File: sarc_tick_if.sv */
// converter clock ticks between control and prescaler
`timescale 1ns/1ps
`default_nettype none
interface sarc_tick_if;
  logic run;
  logic restart;
  logic [2:0] div_sel;
  logic rise;
  logic fall;
  logic hrs;
  modport presc (input run, input restart, input div_sel, output rise, output fall, output hrs);
  modport ctrl (output run, output restart, output div_sel, input rise, input fall, input hrs);
endinterface
`default_nettype wire

/* File: sarc_presc.sv */
// converter clock prescaler with half-rate sync clock
`timescale 1ns/1ps
`default_nettype none
module sarc_presc (
  input wire logic clk,
  input wire logic rst_n,
  sarc_tick_if.presc tick
);
  sarc_pkg::sarc_presc_st_t s;
  sarc_pkg::sarc_presc_st_t n;
  logic [9:0] top;
  logic [9:0] mid;

  always_comb begin
    top = (sarc_pkg::PRESC_BASE << tick.div_sel) - 10'h001; // [R24]
    mid = (sarc_pkg::PRESC_HALF << tick.div_sel) - 10'h001;
    n = s;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (!tick.run || tick.restart) begin
      n = sarc_pkg::PRESC_RST; // [R13] [R9]
    end else begin
      n.cnt = s.cnt + 10'h001;
      if (s.cnt == top) begin
        n.cnt = 10'h000;
        n.rise = 1'b1;
        n.hrs = !s.hrs;
      end
      if (s.cnt == mid) begin
        n.fall = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= sarc_pkg::PRESC_RST;
    end else begin
      s <= n;
    end
  end

  assign tick.rise = s.rise;
  assign tick.fall = s.fall;
  assign tick.hrs = s.hrs;

  a_presc_held: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    !tick.run |=> !tick.rise && !tick.fall && s.cnt == 10'h000)
    else $error("prescaler ran while converter off");
endmodule
`default_nettype wire

/* File: sarc_ctrl.sv */
// conversion control for the 10-bit successive-approximation converter
// Behaviour
// R1 - 10-bit code, zero is ground, full is ref-1lsb
// R2 - channel field picks input and differential gain
// R3 - selections take effect only while converter on
// R4 - result right-aligned, left-aligned on select
// R5 - low byte read locks results until high read
// R6 - done flag still set when result discarded
// R7 - go starts conversion, reads one while busy
// R8 - channel change waits for running conversion end
// R9 - trigger rising edge resets prescaler and starts
// R10 - held level or busy-time edges start nothing
// R11 - software clears trigger flags before next event
// R12 - done flag as trigger means free running
// R13 - prescaler counts while on, held reset otherwise
// R14 - go start waits for next converter clock rise
// R15 - normal 13 cycles, first after enable 25
// R16 - normal sample-and-hold at 1.5 cycles
// R17 - completion writes result, sets flag, clears go
// R18 - auto: sample at 2, total 13.5, +3 sync
// R19 - free running restarts at once, go stays high
// R20 - differential user start: 13 low, 14 high
// R21 - free-running differential repeats take 14 cycles
// R22 - software toggles enable between differential triggers
// R23 - selections frozen in conversion, live in last cycle
// R24 - prescaler divides by power of two from select
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic converter_on,
  input wire logic conversion_go_wr,
  input wire logic auto_trigger_on,
  input wire logic [2:0] trigger_source_select,
  input wire logic [7:0] trigger_in,
  input wire logic done_flag_clr,
  input wire logic left_align_select,
  input wire logic [2:0] clock_divider_select,
  input wire logic [1:0] reference_select,
  input wire logic [4:0] channel_gain_field,
  input wire logic low_byte_rd,
  input wire logic high_byte_rd,
  input wire logic cmp_in,
  output logic conversion_go,
  output logic conversion_done_flag,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  output logic [4:0] mux_channel,
  output logic [1:0] mux_reference,
  output logic [9:0] dac_code,
  output logic sample_hold
);
  sarc_tick_if tick ();
  sarc_pkg::sarc_st_t s;
  sarc_pkg::sarc_st_t n;
  logic trig_lvl;
  logic trig_edge;
  logic live;
  logic done;
  logic free;
  logic samp_now;
  logic [9:0] sar_t;

  sarc_presc u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  assign tick.run = converter_on;
  assign tick.restart = s.tpipe[2];
  assign tick.div_sel = clock_divider_select;

  // gain channels occupy the middle codes of the selection field
  function automatic logic is_diff(input logic [4:0] ch);
    is_diff = (ch >= sarc_pkg::DIFF_LO) && (ch <= sarc_pkg::DIFF_HI); // [R2]
  endfunction

  function automatic sarc_pkg::sarc_st_t start_conv(
    input sarc_pkg::sarc_st_t c,
    input logic aut,
    input logic hrs
  );
    logic ext;
    start_conv = c;
    ext = is_diff(c.chan) && hrs && !aut; // [R20] [R21]
    start_conv.st = sarc_pkg::ST_CONV;
    start_conv.cyc = 5'h00;
    start_conv.go = 1'b1;
    start_conv.auto = aut;
    start_conv.sampled = 1'b0;
    start_conv.bits_on = 1'b0;
    start_conv.end_fall = aut;
    start_conv.samp_fall = !aut;
    if (aut) begin
      start_conv.end_cyc = sarc_pkg::CONV_AUTO_END; // [R18]
      start_conv.samp_cyc = sarc_pkg::SAMP_AUTO;
    end else if (c.first) begin
      start_conv.end_cyc = sarc_pkg::CONV_FIRST_END; // [R15]
      start_conv.samp_cyc = sarc_pkg::SAMP_FIRST;
    end else begin
      start_conv.end_cyc = sarc_pkg::CONV_NORM_END; // [R15]
      start_conv.samp_cyc = sarc_pkg::SAMP_NORM; // [R16]
    end
    if (ext) begin
      start_conv.end_cyc = start_conv.end_cyc + sarc_pkg::DIFF_EXTRA;
      start_conv.samp_cyc = start_conv.samp_cyc + sarc_pkg::DIFF_EXTRA;
    end
  endfunction

  always_comb begin
    n = s;
    n.hold = 1'b0;
    done = 1'b0;
    samp_now = 1'b0;
    sar_t = s.sar;
    // comparator comes from the analog side, so two flops first
    n.cmp_m = cmp_in;
    n.cmp_s = s.cmp_m;
    free = auto_trigger_on && (trigger_source_select == sarc_pkg::TRIG_FREE);
    trig_lvl = trigger_in[trigger_source_select];
    n.trig_d = trig_lvl;
    // only a fresh edge counts; flags left high never retrigger
    trig_edge = trig_lvl && !s.trig_d && auto_trigger_on && !free; // [R11]
    trig_edge = trig_edge && converter_on;
    trig_edge = trig_edge && s.st == sarc_pkg::ST_IDLE && s.tpipe == 3'h0; // [R10]
    n.tpipe = {s.tpipe[1:0], trig_edge}; // [R18]
    if (!converter_on) begin
      n.first = 1'b1;
    end
    live = converter_on && (s.st != sarc_pkg::ST_CONV || s.cyc == s.end_cyc); // [R3]
    if (live) begin
      n.chan = channel_gain_field; // [R23] [R8]
      n.refs = reference_select;
    end
    if (low_byte_rd) begin
      n.lock = 1'b1; // [R5]
    end
    if (high_byte_rd) begin
      n.lock = 1'b0; // [R5]
    end
    if (done_flag_clr) begin
      n.flag = 1'b0;
    end
    if (conversion_go_wr && converter_on) begin
      n.go = 1'b1; // [R7]
    end
    case (s.st)
      sarc_pkg::ST_IDLE: begin
        if (s.tpipe[2]) begin
          n = start_conv(n, 1'b1, tick.hrs); // [R9]
        end else if (conversion_go_wr && converter_on) begin
          n.st = sarc_pkg::ST_WAIT;
        end
      end
      sarc_pkg::ST_WAIT: begin
        if (tick.rise) begin
          n = start_conv(n, 1'b0, tick.hrs); // [R14]
        end
      end
      sarc_pkg::ST_CONV: begin
        if (tick.rise) begin
          n.cyc = s.cyc + 5'h01;
        end
        samp_now = (s.samp_fall ? tick.fall : tick.rise) && s.cyc == s.samp_cyc;
        if (samp_now && !s.sampled) begin
          n.hold = 1'b1; // [R16]
          n.sampled = 1'b1;
          n.bits_on = 1'b1;
          n.bit_idx = sarc_pkg::BIT_TOP;
          n.sar = sarc_pkg::DAC_MID;
          n.dac = sarc_pkg::DAC_MID;
        end else if (tick.rise && s.bits_on && s.cyc != s.samp_cyc) begin
          // skip the rise right after a mid-cycle sample: sync lag would give a stale msb
          // trial bit stays when input is at or above the trial level
          if (!s.cmp_s) begin
            sar_t = sar_t & ~(10'h001 << s.bit_idx); // [R1]
          end
          if (s.bit_idx != 4'h0) begin
            sar_t = sar_t | (10'h001 << (s.bit_idx - 4'h1));
            n.bit_idx = s.bit_idx - 4'h1;
          end else begin
            n.bits_on = 1'b0;
          end
          n.sar = sar_t;
          n.dac = sar_t;
        end
        done = (s.end_fall ? tick.fall : tick.rise) && s.cyc == s.end_cyc;
        if (done) begin
          n.flag = 1'b1; // [R6] [R17]
          n.first = 1'b0;
          if (!s.lock) begin
            n.res = s.sar; // [R5] [R1]
          end
          if (free) begin
            n = start_conv(n, 1'b0, tick.hrs); // [R12] [R19]
          end else if (conversion_go_wr && converter_on) begin
            n.st = sarc_pkg::ST_WAIT;
          end else begin
            n.st = sarc_pkg::ST_IDLE;
            n.go = 1'b0; // [R17]
          end
        end
      end
      default: begin
        n.st = sarc_pkg::ST_IDLE;
      end
    endcase
    if (left_align_select) begin
      n.hi = s.res[9:2]; // [R4]
      n.lo = {s.res[1:0], 6'h00};
    end else begin
      n.hi = {6'h00, s.res[9:8]}; // [R4]
      n.lo = s.res[7:0];
    end
    // switching off aborts any conversion in flight
    if (!converter_on) begin
      n.st = sarc_pkg::ST_IDLE;
      n.go = 1'b0;
      n.tpipe = 3'h0;
      n.bits_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= sarc_pkg::SARC_RST;
    end else begin
      s <= n;
    end
  end

  assign conversion_go = s.go;
  assign conversion_done_flag = s.flag;
  assign result_high_byte = s.hi;
  assign result_low_byte = s.lo;
  assign mux_channel = s.chan;
  assign mux_reference = s.refs;
  assign dac_code = s.dac;
  assign sample_hold = s.hold;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_go_busy: assert property ( // [R7]
    s.st == sarc_pkg::ST_CONV |-> conversion_go)
    else $error("go low during conversion");

  a_go_clears: assert property ( // [R17]
    done && !free && !conversion_go_wr |=> !conversion_go && conversion_done_flag)
    else $error("go not cleared at single completion");

  a_lock_keeps: assert property ( // [R5]
    done && s.lock |=> $stable(s.res))
    else $error("locked result was overwritten");

  a_flag_discard: assert property ( // [R6]
    done && s.lock |=> conversion_done_flag)
    else $error("flag missing on discarded result");

  a_sel_hold: assert property ( // [R8]
    s.st == sarc_pkg::ST_CONV && s.cyc != s.end_cyc |=> $stable(mux_channel))
    else $error("channel changed mid conversion");

  a_off_hold: assert property ( // [R3]
    !converter_on |=> $stable(mux_channel) && $stable(mux_reference))
    else $error("selection applied while off");

  a_left_align: assert property ( // [R4]
    $past(left_align_select) |-> result_low_byte[5:0] == 6'h00)
    else $error("left aligned low bits not zero");

  a_right_align: assert property ( // [R4]
    !$past(left_align_select) |-> result_high_byte[7:2] == 6'h00)
    else $error("right aligned high bits not zero");

  a_free_run: assert property ( // [R19]
    done && free && converter_on |=> s.st == sarc_pkg::ST_CONV ##0 conversion_go)
    else $error("free run did not restart");

  a_edge_ignored: assert property ( // [R10]
    s.st != sarc_pkg::ST_IDLE |=> !s.tpipe[0])
    else $error("trigger edge taken while busy");

  a_auto_start: assert property ( // [R18]
    s.tpipe[2] && converter_on |=> s.st == sarc_pkg::ST_CONV && s.auto)
    else $error("auto trigger did not start conversion");

  a_first_long: assert property ( // [R15]
    s.st == sarc_pkg::ST_WAIT && tick.rise && converter_on && s.first
      |=> s.end_cyc >= sarc_pkg::CONV_FIRST_END)
    else $error("first conversion not extended");

  c_free_run: cover property (done && free);
  c_discard: cover property (done && s.lock);
  c_auto: cover property (s.tpipe[2] && converter_on);
  c_diff_ext: cover property (s.st == sarc_pkg::ST_CONV && s.end_cyc == 5'h0D && !s.auto);
endmodule
`default_nettype wire

/* File: sarc_analog_model.sv */
// behavioural analog front end: sample-and-hold plus comparator
`timescale 1ns/1ps
`default_nettype none
module sarc_analog_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic cmp_in
);
  logic [9:0] held_r;
  // compares the held level, so input changes after sampling are not seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_r <= 10'h000;
    end else if (sample_hold) begin
      held_r <= vin;
    end
    // track the live input while sampling so the first trial is not stale
    cmp_in <= ((sample_hold ? vin : held_r) >= dac_code);
  end
endmodule
`default_nettype wire

/* File: tb_sarc_ctrl.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_sarc_ctrl;
  logic clk, rst_n, converter_on, conversion_go_wr, auto_trigger_on, done_flag_clr;
  logic left_align_select, low_byte_rd, high_byte_rd, cmp_in, sample_hold;
  logic conversion_go, conversion_done_flag;
  logic [2:0] trigger_source_select, clock_divider_select;
  logic [7:0] trigger_in, result_high_byte, result_low_byte;
  logic [1:0] reference_select, mux_reference;
  logic [4:0] channel_gain_field, mux_channel;
  logic [9:0] dac_code, vin;
  logic [9:0] vals [3] = '{10'h3FF, 10'h000, 10'h2A5};
  int mismatches, comparisons, n, sh_cnt, sh0;

  sarc_ctrl sarc_ctrl_inst (.clk, .rst_n, .converter_on, .conversion_go_wr, .auto_trigger_on,
    .trigger_source_select, .trigger_in, .done_flag_clr, .left_align_select,
    .clock_divider_select, .reference_select, .channel_gain_field, .low_byte_rd,
    .high_byte_rd, .cmp_in, .conversion_go, .conversion_done_flag, .result_high_byte,
    .result_low_byte, .mux_channel, .mux_reference, .dac_code, .sample_hold);
  sarc_analog_model sarc_analog_model_inst (.clk, .rst_n, .sample_hold, .dac_code, .vin,
    .cmp_in);

  task automatic results();
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic clr();
    done_flag_clr = 1;
    tick(1);
    done_flag_clr = 0;
  endtask
  task automatic go();
    done_flag_clr = 1;
    conversion_go_wr = 1;
    tick(1);
    done_flag_clr = 0;
    conversion_go_wr = 0;
  endtask
  task automatic rd(input bit high);
    low_byte_rd = !high;
    high_byte_rd = high;
    tick(1);
    low_byte_rd = 0;
    high_byte_rd = 0;
  endtask
  // bounded wait; a hang ends the run as a failure
  task automatic wait_done(output int k);
    k = 0;
    while (conversion_done_flag !== 1'b1) begin
      tick(1);
      k++;
      if (k > 2000) begin
        mismatches++;
        $display("wrong value at %0t: done flag never came", $time);
        results();
      end
    end
  endtask

  always @(posedge clk) begin
    if (sample_hold === 1'b1) sh_cnt++;
  end

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  initial begin
    mismatches = 0;
    comparisons = 0;
    sh_cnt = 0;
    rst_n = 0;
    converter_on = 0;
    conversion_go_wr = 0;
    auto_trigger_on = 0;
    trigger_source_select = 3'h1;
    trigger_in = 8'h00;
    done_flag_clr = 0;
    left_align_select = 0;
    clock_divider_select = 3'h0;
    reference_select = 2'h1;
    channel_gain_field = 5'h03;
    low_byte_rd = 0;
    high_byte_rd = 0;
    vin = 10'h2A5;
    tick(3);
    rst_n = 1;
    tick(2);
    chk(16'({conversion_go, conversion_done_flag}), 16'h0000, "idle after reset");
    chk(16'({mux_reference, mux_channel}), 16'h0000, "selection while off");
    converter_on = 1;
    tick(2);
    chk(16'({mux_reference, mux_channel}), 16'h0023, "selection once on");
    // first conversion after enable, channel changed mid-way
    go();
    tick(1);
    chk(16'(conversion_go), 16'h0001, "go while busy");
    tick(20);
    channel_gain_field = 5'h05;
    tick(2);
    chk(16'(mux_channel), 16'h0003, "selection frozen");
    wait_done(n);
    chk_in(n + 23, 98, 110, "first conversion length");
    chk(16'(conversion_go), 16'h0000, "go cleared at done");
    tick(2);
    chk({result_high_byte, result_low_byte}, 16'h02A5, "right aligned");
    chk(16'(mux_channel), 16'h0005, "new channel applied");
    left_align_select = 1;
    tick(2);
    chk({result_high_byte, result_low_byte}, 16'hA940, "left aligned");
    left_align_select = 0;
    sh0 = sh_cnt;
    foreach (vals[i]) begin
      vin = vals[i];
      go();
      wait_done(n);
      chk_in(n + 1, 50, 58, "normal length");
      tick(2);
      chk({result_high_byte, result_low_byte}, {6'h00, vals[i]}, "code");
    end
    chk_in(sh_cnt - sh0, 3, 3, "one sample per conversion");
    // low byte read locks both bytes until the high byte read
    rd(0);
    vin = 10'h155;
    go();
    wait_done(n);
    tick(2);
    chk(16'(conversion_done_flag), 16'h0001, "flag with result dropped");
    chk({result_high_byte, result_low_byte}, 16'h02A5, "locked bytes");
    rd(1);
    go();
    wait_done(n);
    tick(2);
    chk({result_high_byte, result_low_byte}, 16'h0155, "unlocked bytes");
    // user-started differential conversion, 13 or 14 cycles by sync phase
    channel_gain_field = 5'h08;
    tick(2);
    go();
    wait_done(n);
    chk_in(n + 1, 50, 62, "differential length");
    channel_gain_field = 5'h05;
    tick(2);
    // auto trigger, a second edge mid-conversion, level held past completion
    auto_trigger_on = 1;
    clr();
    trigger_in = 8'h02;
    tick(20);
    trigger_in = 8'h00;
    tick(2);
    trigger_in = 8'h02;
    wait_done(n);
    chk_in(n + 22, 54, 64, "auto conversion length");
    repeat (80) begin
      tick(1);
      if (conversion_go !== 1'b0) n = -1;
    end
    chk_in(n, 0, 9999, "no start from held level");
    trigger_in = 8'h00;
    // free running from the done flag
    trigger_source_select = 3'h0;
    go();
    wait_done(n);
    tick(2);
    chk(16'(conversion_go), 16'h0001, "go held in free run");
    clr();
    wait_done(n);
    chk_in(n + 3, 49, 57, "free run period");
    sh0 = sh_cnt;
    tick(60);
    chk_in(sh_cnt - sh0, 1, 2, "runs with flag left set");
    // disabling holds the prescaler and stops conversions
    converter_on = 0;
    auto_trigger_on = 0;
    tick(2);
    chk(16'(conversion_go), 16'h0000, "stopped when off");
    results();
  end
endmodule
`default_nettype wire
